// ---- rtl/osd_defines.svh ----
// constants for the attribute memory and window block
// assumes a 50 MHz system clock and a 12x18 character cell
`ifndef OSD_DEFINES_SVH
`define OSD_DEFINES_SVH
`define OSD_ROWS       15
`define OSD_COLS       30
`define ROW_ATTR_COL   5'h1E
`define LAST_COL       5'h1F
`define CTRL_ROW       5'h0F
`define CTRL_COLS      19
`define SPF_ROW        5'h10
`define SPF_COLS       8
`define SPACE_DISP     3'h4
`define SPACE_ATTR     3'h5
`define DEV_ADDR       7'h3D
`define PAGE_AB_COL    4
`define PAGE_C_COL     7
`define SHADOW_W_COL   16
`define SHADOW_H_COL   17
`define VERT_HZ        80
`define BLINK_HZ       1
`define BLINK_FRAMES   (`VERT_HZ / (2 * `BLINK_HZ))
`define CELL_DOTS      4'hC
`define CELL_LINES     5'h12
`endif

// ---- rtl/osd_pkg.sv ----
// types shared by the attribute memory and window block
// assumes osd_defines.svh is on the include path
`include "osd_defines.svh"
package osd_pkg;
  typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_ACKA, PH_RX, PH_ACKD, PH_TX, PH_TXACK} phase_t;
  typedef enum logic [1:0] {EX_ROW, EX_COL, EX_DATA, EX_NEXT} expect_t;
  typedef struct packed {
    logic       attr;
    logic [4:0] row;
    logic [4:0] col;
    logic [7:0] data;
  } wr_entry_t;
  typedef struct packed {
    logic [8:0] fontAddr;
    logic [2:0] fgColor;
    logic [2:0] bgColor;
    logic       bgOn;
    logic       show;
    logic       lowerHalf;
    logic       rightHalf;
    logic       winOn;
    logic [2:0] winColor;
    logic       shadow;
  } disp_out_t;
  typedef struct packed {
    logic                   sclS1, sclS2, sclD;
    logic                   sdaS1, sdaS2, sdaD;
    logic                   vsS1, vsS2, vsD;
    phase_t                 phase;
    logic [3:0]             bitCnt;
    logic [7:0]             shift;
    logic                   readMode;
    logic                   sdaDrive_n;
    logic [3:0]             roIdx;
    logic [7:0]             txByte;
    expect_t                want;
    logic                   stream;
    logic                   spaceOk;
    logic                   spaceAttr;
    logic [4:0]             row;
    logic [4:0]             col;
    wr_entry_t [1:0]        fifo;
    logic                   wrPtr;
    logic                   rdPtr;
    logic [1:0]             count;
    logic [449:0][7:0]      code;
    logic [449:0][7:0]      chAttr;
    logic [14:0][7:0]       rowAttr;
    logic [18:0][7:0]       ctrl;
    logic [7:0][7:0]        spf;
    logic [5:0]             frameCnt;
    logic                   blinkOff;
    disp_out_t              dout;
  } state_t;
endpackage

// ---- rtl/osd_attribute_memory_and_windows.sv ----
// serial write decoder, display/attribute memory and window overlay
// assumes scl, sda and vsync come from pins; the rest is on clock
`include "osd_defines.svh"
module osd_attribute_memory_and_windows #(
  parameter int RO_BYTES = 8
) (
  input  wire logic                    clock,
  input  wire logic                    reset_n,
  input  wire logic                    scl,
  input  wire logic                    sdaIn,
  output logic                         sdaOut,
  output logic                         sdaDrive_n,
  input  wire logic                    vsync,
  input  wire logic                    refreshBusy,
  input  wire logic [RO_BYTES*8-1:0]   roData,
  input  wire logic [4:0]              dispRow,
  input  wire logic [4:0]              dispCol,
  input  wire logic [3:0]              dotX,
  input  wire logic [4:0]              lineY,
  output osd_pkg::disp_out_t           dispOut
);
  osd_pkg::state_t st_ff;
  osd_pkg::state_t nxt_st;
  logic            sdaLow_ff;

  // edges seen only on the second synchroniser stage
  logic sclRise, sclFall, startCond, stopCond, vsRise;
  assign sclRise   = st_ff.sclS2 & ~st_ff.sclD;
  assign sclFall   = ~st_ff.sclS2 & st_ff.sclD;
  assign startCond = st_ff.sclS2 & st_ff.sclD & st_ff.sdaD & ~st_ff.sdaS2;
  assign stopCond  = st_ff.sclS2 & st_ff.sclD & ~st_ff.sdaD & st_ff.sdaS2;
  assign vsRise    = st_ff.vsS2 & ~st_ff.vsD;

  function automatic logic [8:0] cellIdx(input logic [4:0] r, input logic [4:0] c);
    cellIdx = 9'({4'h0, r} * 9'd30 + {4'h0, c});
  endfunction

  // per-window hit and shadow decode
  logic [3:0] winHit, winShd;
  genvar w;
  generate
    for (w = 0; w < 4; w++) begin : g_win
      logic [7:0] rowReg, startReg, endReg;
      logic [1:0] wSel, hSel;
      logic [3:0] shW;
      logic [4:0] shH;
      assign rowReg   = st_ff.ctrl[3*w];
      assign startReg = st_ff.ctrl[3*w+1];
      assign endReg   = st_ff.ctrl[3*w+2];
      assign wSel     = st_ff.ctrl[`SHADOW_W_COL][2*w+:2];
      assign hSel     = st_ff.ctrl[`SHADOW_H_COL][2*w+:2];
      assign shW      = {1'b0, wSel, 1'b0} + 4'h2;
      assign shH      = {2'b00, hSel, 1'b0} + 5'h2;
      // start beyond end in rows or columns kills the window
      assign winHit[w] = startReg[2]
        & (rowReg[7:4] <= rowReg[3:0])
        & (startReg[7:3] <= endReg[7:3])
        & (dispRow >= {1'b0, rowReg[7:4]}) & (dispRow <= {1'b0, rowReg[3:0]})
        & (dispCol >= startReg[7:3]) & (dispCol <= endReg[7:3]);
      assign winShd[w] = winHit[w] & startReg[0]
        & (((dispCol == endReg[7:3]) & (dotX >= `CELL_DOTS - shW))
        | ((dispRow == {1'b0, rowReg[3:0]}) & (lineY >= `CELL_LINES - shH)));
    end
  endgenerate

  always_comb begin
    logic             push, pop, isRow, isCol, accept;
    logic [7:0]       b;
    osd_pkg::wr_entry_t e;
    logic [4:0]       mRow, mCol, sr;
    logic             found, lower, dh;
    logic [7:0]       c, a;
    logic [2:0]       pg;
    push   = 1'b0;
    pop    = 1'b0;
    isRow  = 1'b0;
    isCol  = 1'b0;
    accept = 1'b0;
    b      = st_ff.shift;
    e      = st_ff.fifo[st_ff.rdPtr];
    mRow   = 5'h00;
    mCol   = 5'h00;
    sr     = 5'h00;
    found  = 1'b0;
    lower  = 1'b0;
    dh     = 1'b0;
    c      = 8'h00;
    a      = 8'h00;
    pg     = 3'h0;
    nxt_st = st_ff;
    // pin synchronisers
    nxt_st.sclS1 = scl;
    nxt_st.sclS2 = st_ff.sclS1;
    nxt_st.sclD  = st_ff.sclS2;
    nxt_st.sdaS1 = sdaIn;
    nxt_st.sdaS2 = st_ff.sdaS1;
    nxt_st.sdaD  = st_ff.sdaS2;
    nxt_st.vsS1  = vsync;
    nxt_st.vsS2  = st_ff.vsS1;
    nxt_st.vsD   = st_ff.vsS2;
    // blink phase flips every half second of frames
    if (vsRise) begin
      if (st_ff.frameCnt == 6'(`BLINK_FRAMES - 1)) begin
        nxt_st.frameCnt = 6'h00;
        nxt_st.blinkOff = ~st_ff.blinkOff;
      end else begin
        nxt_st.frameCnt = st_ff.frameCnt + 6'h01;
      end
    end
    // serial slave sequencing
    if (startCond) begin
      nxt_st.phase      = osd_pkg::PH_ADDR;
      nxt_st.bitCnt     = 4'h0;
      nxt_st.want       = osd_pkg::EX_ROW;
      nxt_st.stream     = 1'b0;
      nxt_st.sdaDrive_n = 1'b1;
    end else if (stopCond) begin
      nxt_st.phase      = osd_pkg::PH_IDLE;
      nxt_st.sdaDrive_n = 1'b1;
    end else if (sclRise) begin
      case (st_ff.phase)
        osd_pkg::PH_ADDR, osd_pkg::PH_RX: begin
          nxt_st.shift  = {st_ff.shift[6:0], st_ff.sdaS2};
          nxt_st.bitCnt = st_ff.bitCnt + 4'h1;
        end
        osd_pkg::PH_ACKA, osd_pkg::PH_ACKD: nxt_st.bitCnt = 4'h1;
        osd_pkg::PH_TXACK: begin
          if (st_ff.sdaS2) nxt_st.phase = osd_pkg::PH_IDLE;
          else nxt_st.bitCnt = 4'h1;
        end
        default: ;
      endcase
    end else if (sclFall) begin
      case (st_ff.phase)
        osd_pkg::PH_ADDR: begin
          if (st_ff.bitCnt == 4'h8) begin
            if (b[7:1] == `DEV_ADDR) begin
              nxt_st.readMode   = b[0];
              nxt_st.phase      = osd_pkg::PH_ACKA;
              nxt_st.bitCnt     = 4'h0;
              nxt_st.sdaDrive_n = 1'b0;
            end else begin
              nxt_st.phase = osd_pkg::PH_IDLE;
            end
          end
        end
        osd_pkg::PH_RX: begin
          if (st_ff.bitCnt == 4'h8) begin
            isRow = (st_ff.want == osd_pkg::EX_ROW)
              | ((st_ff.want == osd_pkg::EX_NEXT) & b[7]);
            isCol = (st_ff.want == osd_pkg::EX_COL)
              | ((st_ff.want == osd_pkg::EX_NEXT) & ~b[7]);
            // a full buffer refuses only bytes it would have to store
            accept = isRow | isCol | ~st_ff.spaceOk
              | (st_ff.count != 2'h2);
            nxt_st.phase  = osd_pkg::PH_ACKD;
            nxt_st.bitCnt = 4'h0;
            if (accept) begin
              nxt_st.sdaDrive_n = 1'b0;
              if (isRow) begin
                nxt_st.spaceAttr = b[7:5] == `SPACE_ATTR;
                nxt_st.spaceOk   = (b[7:5] == `SPACE_ATTR) | (b[7:5] == `SPACE_DISP);
                nxt_st.row       = b[4:0];
                nxt_st.want      = osd_pkg::EX_COL;
              end else if (isCol) begin
                nxt_st.col    = b[4:0];
                nxt_st.stream = b[6];
                nxt_st.want   = osd_pkg::EX_DATA;
              end else begin
                push = st_ff.spaceOk;
                // only a data byte frees bit 7 to mean row or column again
                if (!st_ff.stream) nxt_st.want = osd_pkg::EX_NEXT;
                if (st_ff.stream) begin
                  if (st_ff.col == `LAST_COL) begin
                    nxt_st.col = 5'h00;
                    nxt_st.row = st_ff.row + 5'h01;
                  end else begin
                    nxt_st.col = st_ff.col + 5'h01;
                  end
                end
              end
            end
          end
        end
        osd_pkg::PH_ACKA: begin
          if (st_ff.bitCnt == 4'h1) begin
            nxt_st.bitCnt = 4'h0;
            if (st_ff.readMode) begin
              nxt_st.phase      = osd_pkg::PH_TX;
              nxt_st.roIdx      = 4'h0;
              nxt_st.txByte     = roData[7:0];
              nxt_st.sdaDrive_n = roData[7];
            end else begin
              nxt_st.phase      = osd_pkg::PH_RX;
              nxt_st.sdaDrive_n = 1'b1;
            end
          end
        end
        osd_pkg::PH_ACKD: begin
          if (st_ff.bitCnt == 4'h1) begin
            nxt_st.phase      = osd_pkg::PH_RX;
            nxt_st.bitCnt     = 4'h0;
            nxt_st.sdaDrive_n = 1'b1;
          end
        end
        osd_pkg::PH_TX: begin
          if (st_ff.bitCnt == 4'h7) begin
            nxt_st.phase      = osd_pkg::PH_TXACK;
            nxt_st.bitCnt     = 4'h0;
            nxt_st.sdaDrive_n = 1'b1;
          end else begin
            nxt_st.bitCnt     = st_ff.bitCnt + 4'h1;
            nxt_st.txByte     = {st_ff.txByte[6:0], 1'b0};
            nxt_st.sdaDrive_n = st_ff.txByte[6];
          end
        end
        osd_pkg::PH_TXACK: begin
          if (st_ff.bitCnt == 4'h1) begin
            // fixed order, wrapping after the last read-only byte
            nxt_st.roIdx = (st_ff.roIdx == 4'(RO_BYTES - 1)) ? 4'h0
                           : st_ff.roIdx + 4'h1;
            nxt_st.txByte     = roData[nxt_st.roIdx*8+:8];
            nxt_st.sdaDrive_n = nxt_st.txByte[7];
            nxt_st.phase      = osd_pkg::PH_TX;
            nxt_st.bitCnt     = 4'h0;
          end
        end
        default: ;
      endcase
    end
    // two-entry buffer; refresh traffic stalls the drain
    pop = (st_ff.count != 2'h0) & ~refreshBusy;
    if (push) begin
      nxt_st.fifo[st_ff.wrPtr] = '{st_ff.spaceAttr, st_ff.row, st_ff.col, b};
      nxt_st.wrPtr = ~st_ff.wrPtr;
    end
    if (pop) begin
      nxt_st.rdPtr = ~st_ff.rdPtr;
      // unmapped spots, dummy columns included, store nothing
      if (!e.attr) begin
        if (e.row < 5'(`OSD_ROWS) && e.col < 5'(`OSD_COLS))
          nxt_st.code[cellIdx(e.row, e.col)] = e.data;
      end else if (e.row < 5'(`OSD_ROWS)) begin
        if (e.col < 5'(`OSD_COLS))
          nxt_st.chAttr[cellIdx(e.row, e.col)] = e.data;
        else if (e.col == `ROW_ATTR_COL)
          nxt_st.rowAttr[e.row[3:0]] = e.data;
      end else if (e.row == `CTRL_ROW && e.col < 5'(`CTRL_COLS)) begin
        nxt_st.ctrl[e.col] = e.data;
      end else if (e.row == `SPF_ROW && e.col < 5'(`SPF_COLS)) begin
        nxt_st.spf[e.col[2:0]] = e.data;
      end
    end
    nxt_st.count = st_ff.count + {1'b0, push} - {1'b0, pop};
    // screen row to memory row, double-height rows take two
    for (int m = 0; m < `OSD_ROWS; m++) begin
      dh = st_ff.rowAttr[m][1];
      if (!found && dispRow >= sr && dispRow < sr + (dh ? 5'h2 : 5'h1)) begin
        found = 1'b1;
        mRow  = 5'(m);
        lower = dispRow != sr;
      end
      sr = sr + (dh ? 5'h2 : 5'h1);
    end
    // odd memory columns never reach the screen on wide rows
    if (found && st_ff.rowAttr[mRow[3:0]][0])
      mCol = {dispCol[4:1], 1'b0};
    else
      mCol = dispCol;
    found = found & (dispCol < 5'(`OSD_COLS));
    c = st_ff.code[cellIdx(mRow, mCol)];
    a = st_ff.chAttr[cellIdx(mRow, mCol)];
    case (c[7:6])
      2'h1:    pg = st_ff.spf[`PAGE_AB_COL][2:0];
      2'h2:    pg = st_ff.spf[`PAGE_AB_COL][6:4];
      2'h3:    pg = st_ff.spf[`PAGE_C_COL][2:0];
      default: pg = 3'h0;
    endcase
    nxt_st.dout.fontAddr  = (c[7:6] == 2'h0) ? {3'h0, c[5:0]}
                            : {pg + 3'h1, c[5:0]};
    nxt_st.dout.fgColor   = a[2:0];
    nxt_st.dout.bgColor   = a[6:4];
    nxt_st.dout.bgOn      = found & (a[6:4] != 3'h0);
    nxt_st.dout.show      = found & ~(a[3] & st_ff.blinkOff);
    nxt_st.dout.lowerHalf = lower;
    nxt_st.dout.rightHalf = st_ff.rowAttr[mRow[3:0]][0] & dispCol[0];
    nxt_st.dout.winOn     = 1'b0;
    nxt_st.dout.winColor  = 3'h0;
    nxt_st.dout.shadow    = 1'b0;
    // walk lowest priority first so window 1 lands last
    for (int k = 3; k >= 0; k--) begin
      if (winHit[k]) begin
        nxt_st.dout.winOn    = 1'b1;
        nxt_st.dout.winColor = st_ff.ctrl[3*k+2][2:0];
        nxt_st.dout.shadow   = winShd[k];
      end
    end
  end

  // single state register; memories clear to zero
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_ff            <= '0;
      st_ff.sclS1      <= 1'b1;
      st_ff.sclS2      <= 1'b1;
      st_ff.sclD       <= 1'b1;
      st_ff.sdaS1      <= 1'b1;
      st_ff.sdaS2      <= 1'b1;
      st_ff.sdaD       <= 1'b1;
      st_ff.sdaDrive_n <= 1'b1;
      sdaLow_ff        <= 1'b0;
    end else begin
      st_ff            <= nxt_st;
      sdaLow_ff        <= 1'b0;
    end
  end

  assign sdaOut     = sdaLow_ff;   // open drain: only ever pulls low
  assign sdaDrive_n = st_ff.sdaDrive_n;
  assign dispOut    = st_ff.dout;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  property p_attr_row;
    sclFall && st_ff.phase == osd_pkg::PH_RX && st_ff.bitCnt == 4'h8
      && st_ff.want == osd_pkg::EX_ROW && st_ff.shift[7:5] == 3'h5
      |=> st_ff.spaceAttr && st_ff.spaceOk;
  endproperty
  a_attr_row: assert property (p_attr_row)
    else $error("attribute row byte not decoded");

  property p_stream_inc;
    sclFall && st_ff.phase == osd_pkg::PH_RX && st_ff.bitCnt == 4'h8
      && st_ff.want == osd_pkg::EX_DATA && st_ff.stream && st_ff.col != 5'h1F
      |=> st_ff.col == $past(st_ff.col) + 5'h01 && st_ff.row == $past(st_ff.row);
  endproperty
  a_stream_inc: assert property (p_stream_inc)
    else $error("streaming column did not advance");

  property p_dummy_drop;
    st_ff.count != 2'h0 && !refreshBusy && st_ff.fifo[st_ff.rdPtr].col == 5'h1F
      |=> $stable(st_ff.rowAttr) && $stable(st_ff.chAttr) && $stable(st_ff.code);
  endproperty
  a_dummy_drop: assert property (p_dummy_drop)
    else $error("column 31 byte changed storage");

  property p_win1_wins;
    winHit[0] |=> dispOut.winOn && dispOut.winColor == $past(st_ff.ctrl[2][2:0]);
  endproperty
  a_win1_wins: assert property (p_win1_wins)
    else $error("window 1 colour lost on overlap");

  property p_win_order;
    st_ff.ctrl[1][7:3] > st_ff.ctrl[2][7:3] |-> !winHit[0];
  endproperty
  a_win_order: assert property (p_win_order)
    else $error("inverted window displayed");

  property p_blink_period;
    $changed(st_ff.blinkOff) |-> $past(st_ff.frameCnt) == 6'd39;
  endproperty
  a_blink_period: assert property (p_blink_period)
    else $error("blink toggled off period");

  property p_ack_data;
    sclFall && st_ff.phase == osd_pkg::PH_RX && st_ff.bitCnt == 4'h8
      && st_ff.count != 2'h2 ##1 !sclFall [*2] |-> !sdaDrive_n;
  endproperty
  a_ack_data: assert property (p_ack_data)
    else $error("data byte not acknowledged");

  property p_bg_clear;
    ##1 $past(st_ff.chAttr[cellIdx(dispRow, dispCol)][6:4]) == 3'h0
      && $past(st_ff.rowAttr[0][0]) == 1'b0 && $past(dispRow) == 5'h00
      |-> !dispOut.bgOn;
  endproperty
  a_bg_clear: assert property (p_bg_clear)
    else $error("transparent background shown");

  property p_wide_odd;
    dispRow == 5'h00 && st_ff.rowAttr[0][0] && dispCol[0] |=> dispOut.rightHalf;
  endproperty
  a_wide_odd: assert property (p_wide_odd)
    else $error("odd column shown on wide row");
endmodule // osd_attribute_memory_and_windows

// ---- testbench/serial_master_model.sv ----
// behavioural two-wire bus master for the attribute block's serial pins
// assumes a pull-up on the data wire; scl stands high between frames
module serial_master_model (
  output logic      scl,
  output logic      sdaPull_n,
  input  wire logic sdaWire
);
  timeunit 1ns;
  timeprecision 1ns;

  // both lines released while idle
  initial begin
    scl = 1'b1;
    sdaPull_n = 1'b1;
  end

  // start: data falls while the clock is high
  task automatic startFrame();
    #40 sdaPull_n = 1'b1;
    #40 scl = 1'b1;
    #80 sdaPull_n = 1'b0;
    #80 scl = 1'b0;
  endtask

  // stop: data rises while the clock is high, then the clock stands still
  task automatic stopFrame();
    #40 sdaPull_n = 1'b0;
    #40 scl = 1'b1;
    #80 sdaPull_n = 1'b1;
    #80;
  endtask

  // data changes mid low phase; ack sampled mid high phase, well after the
  // device's three-clock answer delay
  task automatic putByte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      scl = 1'b0;
      #40 sdaPull_n = b[i];
      #40 scl = 1'b1;
      #80;
    end
    scl = 1'b0;
    #40 sdaPull_n = 1'b1;
    #40 scl = 1'b1;
    #40 ack = ~sdaWire;
    #40 scl = 1'b0;
  endtask

  // read one byte msb first; last=1 answers with a nack
  task automatic getByte(input logic last, output logic [7:0] b);
    sdaPull_n = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      scl = 1'b0;
      #80 scl = 1'b1;
      #40 b[i] = sdaWire;
      #40;
    end
    scl = 1'b0;
    #40 sdaPull_n = last;
    #40 scl = 1'b1;
    #80 scl = 1'b0;
    #40 sdaPull_n = 1'b1;
  endtask
endmodule // serial_master_model

// ---- testbench/testbench.sv ----
// self-checking bench: serial writes in all formats, reads, display lookups
// assumes the serial master model and the design files are compiled first
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  logic               clock;
  logic               reset_n;
  logic               vsync;
  logic               refreshBusy;
  logic [63:0]        roData;
  logic [4:0]         dispRow;
  logic [4:0]         dispCol;
  logic [3:0]         dotX;
  logic [4:0]         lineY;
  logic               scl;
  logic               mPull_n;
  logic               sdaOut;
  logic               sdaDrive_n;
  wire                sdaWire;
  osd_pkg::disp_out_t dispOut;
  int                 errorCnt;
  int                 cmpCount;
  logic [31:0]        a;
  logic [7:0]         b;

  // pulled-up wire: low when either party pulls it
  assign sdaWire = mPull_n & (sdaDrive_n | sdaOut);

  osd_attribute_memory_and_windows #(.RO_BYTES(8)) DUT (
    .clock(clock), .reset_n(reset_n), .scl(scl), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaDrive_n(sdaDrive_n), .vsync(vsync),
    .refreshBusy(refreshBusy), .roData(roData), .dispRow(dispRow),
    .dispCol(dispCol), .dotX(dotX), .lineY(lineY), .dispOut(dispOut)
  );

  serial_master_model m (.scl(scl), .sdaPull_n(mPull_n), .sdaWire(sdaWire));

  // 50 MHz system clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      errorCnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic printVerdict();
    $display("mismatches=%0d comparisons=%0d", errorCnt, cmpCount);
    if (errorCnt == 0 && cmpCount > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // one write frame; bit i of acks is the ack of byte i
  task automatic frame(input logic [7:0] q[$], output logic [31:0] acks);
    logic k;
    acks = '0;
    m.startFrame();
    foreach (q[i]) begin
      m.putByte(q[i], k);
      acks[i] = k;
    end
    m.stopFrame();
  endtask

  // lookup answers one cycle after the position is presented
  task automatic look(input logic [4:0] r, input logic [4:0] c, input logic [3:0] x);
    @(posedge clock);
    #1 dispRow = r;
    dispCol = c;
    dotX = x;
    @(posedge clock);
    #1;
  endtask

  task automatic frames(input int n);
    repeat (n) begin
      @(posedge clock);
      #1 vsync = 1'b1;
      repeat (3) @(posedge clock);
      #1 vsync = 1'b0;
      repeat (3) @(posedge clock);
    end
  endtask

  // hang guard well above the bench's run time
  initial begin
    #1ms;
    errorCnt++;
    printVerdict();
  end

  initial begin
    reset_n = 1'b0;
    vsync = 1'b0;
    refreshBusy = 1'b0;
    roData = 64'h8877_6655_4433_2211;
    dispRow = 5'h00;
    dispCol = 5'h00;
    dotX = 4'h0;
    lineY = 5'h00;
    repeat (12) @(posedge clock);
    check({sdaDrive_n, dispOut}, {1'b1, 24'h00_0000});
    #1 reset_n = 1'b1;
    repeat (3) @(posedge clock);
    frame({8'h70, 8'hA2}, a);
    check(a, 32'h0000_0000);
    // per-item display code then attribute
    frame({8'h7A, 8'h82, 8'h05, 8'h45, 8'hA2, 8'h05, 8'h2B}, a);
    check(a, 32'h0000_007F);
    look(5'h02, 5'h05, 4'h0);
    check({dispOut.fontAddr, dispOut.fgColor, dispOut.bgColor, dispOut.bgOn, dispOut.show},
          {9'h045, 3'h3, 3'h2, 2'b11});
    // blink half period is forty frames
    frames(39);
    look(5'h02, 5'h05, 4'h0);
    check(dispOut.show, 1'b1);
    frames(1);
    look(5'h02, 5'h05, 4'h0);
    check(dispOut.show, 1'b0);
    // bank a moved to page 2, bank b to page 3
    frame({8'h7A, 8'hB0, 8'h04, 8'h32}, a);
    look(5'h02, 5'h05, 4'h0);
    check(dispOut.fontAddr, 9'h0C5);
    // stalled drain: third stored byte refused and lost
    refreshBusy = 1'b1;
    frame({8'h7A, 8'h82, 8'h04, 8'h07, 8'h06, 8'h91, 8'h07, 8'h22}, a);
    check(a, 32'h0000_007F);
    refreshBusy = 1'b0;
    look(5'h02, 5'h07, 4'h0);
    check(dispOut.fontAddr, 9'h000);
    look(5'h02, 5'h06, 4'h0);
    check(dispOut.fontAddr, 9'h111);
    // double width on row 2, double height on row 0
    frame({8'h7A, 8'hA2, 8'h1E, 8'h01, 8'hA0, 8'h1E, 8'h02}, a);
    look(5'h03, 5'h05, 4'h0);
    check({dispOut.fontAddr, dispOut.rightHalf}, {9'h007, 1'b1});
    look(5'h03, 5'h04, 4'h0);
    check({dispOut.fontAddr, dispOut.lowerHalf}, {9'h007, 1'b0});
    look(5'h01, 5'h04, 4'h0);
    check({dispOut.fontAddr, dispOut.lowerHalf}, {9'h000, 1'b1});
    // streaming across the row end, dummy at column 31; stays streaming to stop
    frame({8'h7A, 8'hA3, 8'h5D, 8'h01, 8'h00, 8'hFF, 8'h04}, a);
    check(a, 32'h0000_007F);
    look(5'h04, 5'h1D, 4'h0);
    check(dispOut.fgColor, 3'h1);
    look(5'h05, 5'h00, 4'h0);
    check(dispOut.fgColor, 3'h4);
    // reserved row acked, nothing aliased
    frame({8'h7A, 8'hB4, 8'h00, 8'h55}, a);
    check(a, 32'h0000_000F);
    look(5'h05, 5'h00, 4'h0);
    check(dispOut.fgColor, 3'h4);
    // four windows streamed into row 15 columns 0..11
    frame({8'h7A, 8'hAF, 8'h40, 8'h13, 8'h14, 8'h35, 8'h13, 8'h25, 8'h53,
           8'h13, 8'h6C, 8'h67, 8'h13, 8'h60, 8'h72}, a);
    check(a, 32'h0000_7FFF);
    look(5'h02, 5'h05, 4'h0);
    check({dispOut.winOn, dispOut.winColor}, {1'b1, 3'h5});
    look(5'h02, 5'h08, 4'h0);
    check({dispOut.winOn, dispOut.winColor}, {1'b1, 3'h3});
    look(5'h02, 5'h0A, 4'hB);
    check(dispOut.shadow, 1'b1);
    look(5'h02, 5'h0A, 4'h9);
    check(dispOut.shadow, 1'b0);
    lineY = 5'h11;
    look(5'h03, 5'h08, 4'h0);
    check(dispOut.shadow, 1'b1);
    lineY = 5'h00;
    look(5'h02, 5'h0C, 4'h0);
    check(dispOut.winOn, 1'b0);
    look(5'h02, 5'h0D, 4'h0);
    check(dispOut.winOn, 1'b0);
    frame({8'h7A, 8'hAF, 8'h0A, 8'h64}, a);
    look(5'h02, 5'h0D, 4'h0);
    check({dispOut.winOn, dispOut.winColor}, {1'b1, 3'h2});
    // read-only bytes in fixed order
    m.startFrame();
    m.putByte(8'h7B, a[0]);
    check(a[0], 1'b1);
    m.getByte(1'b0, b);
    check(b, 8'h11);
    m.getByte(1'b1, b);
    check(b, 8'h22);
    m.stopFrame();
    printVerdict();
  end
endmodule // testbench
